/* bench/capture_unit_tb_top.sv */
// Self-checking testbench of the capture unit with hold, compare and reload registers.
`timescale 1ns/1ps
`default_nettype none
module capture_unit_tb_top;
  import capture_pkg::*;

  // ****************************************
  // Signals and expectations.
  // ****************************************
  logic              clk     = 1'b0;
  logic              rstn    = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = 8'h00;
  logic [31:0]       pwdata  = 32'h00000000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [NCH-1:0]    cap_in  = 3'h0;
  logic              irq;
  int                errors  = 0;
  int                n_tests = 0;
  int                ch;
  logic [2:0]        en;
  logic [31:0]       rd, v, c, hold_exp [NCH];
  logic              er;
  localparam logic [31:0] FN  = 32'h1 << B_CAPTURE_FN;
  localparam logic [31:0] CMP = 32'h1 << B_COMPARE_EN;
  localparam logic [31:0] RLD = 32'h1 << B_RELOAD_EN;
  localparam logic [31:0] CLR = 32'h1 << B_CLEAR_ON_CAP;
  localparam logic [31:0] CNT = 32'h1 << B_COUNT_EN;
  localparam logic [31:0] CMI = 32'h1 << B_CMP_IRQ_EN;
  localparam logic [31:0] CCL = 32'h1 << B_CLEAR_ON_CMP;
  localparam logic [ADDR_W-1:0] REG_OFS [5] = '{OFS_HOLD_0, OFS_HOLD_1, OFS_HOLD_2, OFS_COMPARE, OFS_CONTROL_0};

  always #20 clk = ~clk;

  capture_unit dut (
    .i_clk           (clk),
    .i_rstn          (rstn),
    .i_psel          (psel),
    .i_penable       (penable),
    .i_pwrite        (pwrite),
    .i_paddr         (paddr),
    .i_pwdata        (pwdata),
    .o_prdata        (prdata),
    .o_pready        (pready),
    .o_pslverr       (pslverr),
    .i_capture_input (cap_in),
    .o_irq           (irq)
  );

  // ****************************************
  // Tasks and expectation functions.
  // ****************************************
  function automatic int div_of(input int k);
    return (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 16 : 32;
  endfunction : div_of

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // A transfer holds its request until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(name, exp, rd);
  endtask : rdc

  task automatic pulse(input int k);
    @(posedge clk);
    cap_in <= 3'h1 << k;
    @(posedge clk);
    cap_in <= 3'h0;
    @(posedge clk);
  endtask : pulse

  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    #(40 * 20000);
    errors++;
    $display("ERROR watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    void'($urandom(32'h1DB802BF));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) rdc("reset_value", REG_OFS[i], RST_WORD);
    for (int i = 0; i < 4; i++) begin
      wr(REG_OFS[i], 32'hFFFFFFFF);
      rdc("reserved_bits", REG_OFS[i], 32'h00FFFFFF);
    end
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped_error", 32'h1, {31'h0, er});
    wr(OFS_STATUS, 32'hFFFFFFFF);
    chk("status_write_error", 32'h1, {31'h0, er});
    $display("test registers finished");
    for (int i = 0; i < 3; i++) hold_exp[i] = 32'h00FFFFFF;
    for (int r = 0; r < 8; r++) begin
      ch = $urandom_range(2);
      en = (r == 0) ? 3'h7 : 3'($urandom_range(7));
      v = $urandom & 32'h00FFFFFF;
      wr(OFS_CONTROL_0, FN | (32'(en) << B_CH_EN_LO));
      wr(OFS_COUNTER, v);
      pulse(ch);
      if (en[ch]) hold_exp[ch] = v;
      for (int i = 0; i < 3; i++) rdc("capture_hold", REG_OFS[i], hold_exp[i]);
    end
    $display("test capture finished");
    for (int m = 0; m < 2; m++) begin
      c = $urandom & 32'h00FFFFFF;
      v = $urandom & 32'h00FFFFFF;
      wr(OFS_COMPARE, c);
      wr(OFS_CONTROL_0, FN | (32'h1 << B_CH_EN_LO) | ((m == 1) ? RLD : CLR));
      wr(OFS_COUNTER, v);
      pulse(0);
      rdc("capture_hold", OFS_HOLD_0, v);
      rdc("counter_after_capture", OFS_COUNTER, (m == 1) ? c : 32'h0);
    end
    $display("test capture_reload finished");
    for (int m = 0; m < 2; m++) begin
      c = $urandom_range(200, 1) << 16;
      wr(OFS_CONTROL_0, 32'h0);
      wr(OFS_COMPARE, c);
      wr(OFS_COUNTER, 32'h00FFFFF0);
      wr(OFS_CLEAR, 32'h1F);
      wr(OFS_CONTROL_0, FN | CNT | ((m == 1) ? RLD : 32'h0));
      repeat (40) @(posedge clk);
      wr(OFS_CONTROL_0, 32'h0);
      apb(1'b0, OFS_COUNTER, 32'h0);
      chk("counter_after_overflow", (m == 1) ? c : 32'h0, rd & 32'hFFFF0000);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("overflow_flag", 32'h1, {31'h0, rd[ST_OVF]});
    end
    $display("test overflow finished");
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CONTROL_1, 32'(k));
      wr(OFS_COUNTER, 32'h0);
      wr(OFS_CONTROL_0, FN | CNT);
      repeat (640) @(posedge clk);
      wr(OFS_CONTROL_0, 32'h0);
      apb(1'b0, OFS_COUNTER, 32'h0);
      chk("divide_rate", 32'h1, {31'h0, (rd <= 648 / div_of(k) + 1) && (rd + 1 >= 640 / div_of(k))});
    end
    wr(OFS_CONTROL_1, 32'h0);
    $display("test divide finished");
    wr(OFS_CLEAR, 32'h1F);
    wr(OFS_COUNTER, 32'h0);
    wr(OFS_COMPARE, 32'h28);
    wr(OFS_CONTROL_0, FN | CNT | CMI);
    repeat (80) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("match_flag_disabled", 32'h0, {31'h0, rd[ST_CMP]});
    wr(OFS_CONTROL_0, 32'h0);
    wr(OFS_COUNTER, 32'h0);
    wr(OFS_CONTROL_0, FN | CNT | CMP | CMI | CCL);
    repeat (80) @(posedge clk);
    wr(OFS_CONTROL_0, FN | CMP | CMI);
    apb(1'b0, OFS_COUNTER, 32'h0);
    chk("clear_on_compare", 32'h1, {31'h0, rd <= 32'h28});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("match_flag", 32'h1, {31'h0, rd[ST_CMP]});
    chk("irq_raised", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_EN, 32'h1 << ST_CMP);
    rdc("irq_enable", OFS_IRQ_EN, 32'h1 << ST_CMP);
    repeat (2) @(posedge clk);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(OFS_CLEAR, 32'h1 << ST_CMP);
    repeat (2) @(posedge clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    $display("test compare finished");
    summarize();
  end
endmodule : capture_unit_tb_top
`default_nettype wire

/* logic/capture_pkg.sv */
// Package with the register map, field positions and constants of the capture unit.
package capture_pkg;

  localparam int unsigned CNT_W  = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NCH    = 3;

  // ****************************************
  // Register byte offsets.
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_COUNTER   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_HOLD_0    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HOLD_1    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_HOLD_2    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COMPARE   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_0 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_1 = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CLEAR     = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h24;

  // ****************************************
  // Control register 0 field positions.
  // ****************************************
  localparam int unsigned B_CAPTURE_FN    = 29;
  localparam int unsigned B_COMPARE_EN    = 28;
  localparam int unsigned B_RELOAD_EN     = 27;
  localparam int unsigned B_CLEAR_ON_CAP  = 26;
  localparam int unsigned B_CLEAR_ON_CMP  = 25;
  localparam int unsigned B_COUNT_EN      = 24;
  localparam int unsigned B_CMP_IRQ_EN    = 21;
  localparam int unsigned B_OVF_IRQ_EN    = 20;
  localparam int unsigned B_CAP_IRQ_EN_LO = 16;
  localparam int unsigned B_CH_EN_LO      = 4;

  // ****************************************
  // Status, clear and enable layout.
  // ****************************************
  localparam int unsigned ST_W       = 5;
  localparam int unsigned ST_OVF     = 3;
  localparam int unsigned ST_CMP     = 4;
  localparam int unsigned DIV_SEL_LO = 0;

  localparam logic [CNT_W-1:0] CNT_MAX   = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 24'h000000;
  localparam logic [31:0]      RST_WORD  = 32'h00000000;

  // ****************************************
  // Prescaler terminal counts for divide by 1, 4, 16, 32.
  // ****************************************
  localparam logic [4:0] DIV_TC_1  = 5'h00;
  localparam logic [4:0] DIV_TC_4  = 5'h03;
  localparam logic [4:0] DIV_TC_16 = 5'h0F;
  localparam logic [4:0] DIV_TC_32 = 5'h1F;

endpackage : capture_pkg

/* logic/capture_prescaler.sv */
// Clock divider that turns the system clock into a one-cycle counting tick.
`timescale 1ns/1ps
`default_nettype none
module capture_prescaler (
  input  wire logic       i_clk,     // System clock.
  input  wire logic       i_rstn,    // Asynchronous reset, active low.
  input  wire logic       i_enable,  // Counting enabled.
  input  wire logic [1:0] i_div_sel, // Divide select.
  output logic            o_tick     // One-cycle counting tick.
);
  import capture_pkg::*;

  logic [4:0] div_count;
  logic [4:0] next_div_count;
  logic [4:0] terminal;
  logic       next_tick;

  always_comb begin
    case (i_div_sel)
      2'h0:    terminal = DIV_TC_1;
      2'h1:    terminal = DIV_TC_4;
      2'h2:    terminal = DIV_TC_16;
      default: terminal = DIV_TC_32;
    endcase
    next_div_count = div_count;
    next_tick      = 1'b0;
    if (!i_enable) begin
      next_div_count = DIV_TC_1;
    end else if (div_count >= terminal) begin
      next_div_count = DIV_TC_1;
      next_tick      = 1'b1;
    end else begin
      next_div_count = div_count + 5'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_count <= 5'h00;
      o_tick    <= 1'b0;
    end else begin
      div_count <= next_div_count;
      o_tick    <= next_tick;
    end
  end

endmodule : capture_prescaler
`default_nettype wire

/* logic/capture_unit.sv */
// Three-channel input capture unit with hold, compare and reload registers on APB.
//
// Contract
// - A valid edge on an enabled channel copies the 24-bit counter into its hold.
// - Three hold registers, each updated only by its own capture input or by an APB write to its offset.
// - With compare enable set, the compare register is the counter's match target.
// - With reload enable set, overflow or capture loads the compare value into the counter.
// - 24-bit up counter advancing on a tick divided by 1, 4, 16 or 32.
// - With compare enable set, counter reaching compare value sets the match flag; interrupt if its enable set.
// - Overflow without reload restarts the counter from zero.
// - Clear-on-capture resets the counter to zero after a capture event when reload enable is clear; reload takes priority.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module capture_unit (
  input  wire logic                           i_clk,           // System clock, 25 MHz.
  input  wire logic                           i_rstn,          // Asynchronous reset, active low.
  input  wire logic                           i_psel,          // APB select.
  input  wire logic                           i_penable,       // APB enable.
  input  wire logic                           i_pwrite,        // APB write.
  input  wire logic [capture_pkg::ADDR_W-1:0] i_paddr,         // APB byte address.
  input  wire logic [31:0]                    i_pwdata,        // APB write data.
  output logic      [31:0]                    o_prdata,        // APB read data.
  output logic                                o_pready,        // APB ready.
  output logic                                o_pslverr,       // APB error on unmapped address.
  input  wire logic [capture_pkg::NCH-1:0]    i_capture_input, // Capture inputs 0 to 2.
  output logic                                o_irq            // Level interrupt.
);
  import capture_pkg::*;

  // ****************************************
  // State.
  // ****************************************
  logic [CNT_W-1:0] capture_counter;
  logic [CNT_W-1:0] next_capture_counter;
  logic [CNT_W-1:0] capture_hold_value [NCH];
  logic [CNT_W-1:0] next_capture_hold_value [NCH];
  logic [CNT_W-1:0] counter_compare_reload;
  logic [CNT_W-1:0] next_counter_compare_reload;
  logic [31:0]      capture_control_0;
  logic [31:0]      next_capture_control_0;
  logic [1:0]       div_sel;
  logic [1:0]       next_div_sel;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  next_status;
  logic [NCH-1:0]   input_prev;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;
  logic             next_irq;

  logic             tick;
  logic             wr_access;
  logic             map_hit;
  logic [NCH-1:0]   capture_evt;
  logic             capture_any;
  logic             counter_overflow_event;
  logic             compare_hit;
  logic [ST_W-1:0]  irq_en;
  logic             compare_enable;
  logic             reload_enable;
  logic             clear_on_capture;

  // Gathers the interrupt enables of a control word into the status layout.
  function automatic logic [ST_W-1:0] next_irq_en(input logic [31:0] ctl);
    next_irq_en = {ctl[B_CMP_IRQ_EN], ctl[B_OVF_IRQ_EN], ctl[B_CAP_IRQ_EN_LO +: NCH]};
  endfunction : next_irq_en

  assign compare_enable   = capture_control_0[B_COMPARE_EN];
  assign reload_enable    = capture_control_0[B_RELOAD_EN];
  assign clear_on_capture = capture_control_0[B_CLEAR_ON_CAP];
  assign irq_en           = next_irq_en(capture_control_0);
  assign wr_access = i_psel && i_penable && o_pready && i_pwrite;

  // ****************************************
  // Counting tick.
  // ****************************************
  // divided counting tick
  capture_prescaler u_prescaler (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_enable  (capture_control_0[B_CAPTURE_FN] && capture_control_0[B_COUNT_EN]),
    .i_div_sel (div_sel),
    .o_tick    (tick)
  );

  // ****************************************
  // Events.
  // ****************************************
  // per-channel edge detect
  always_comb begin
    capture_evt = i_capture_input & ~input_prev & capture_control_0[B_CH_EN_LO +: NCH]
                  & {NCH{capture_control_0[B_CAPTURE_FN]}};
  end
  assign capture_any            = |capture_evt;
  assign counter_overflow_event = tick && (capture_counter == CNT_MAX);
  assign compare_hit            = tick && compare_enable && (capture_counter == counter_compare_reload);

  // ****************************************
  // Counter and hold registers.
  // ****************************************
  always_comb begin
    next_capture_counter = capture_counter;
    if (wr_access && i_paddr == OFS_COUNTER) begin
      next_capture_counter = i_pwdata[CNT_W-1:0];
    end else if (capture_any && reload_enable) begin
      next_capture_counter = counter_compare_reload;
    end else if (capture_any && clear_on_capture) begin
      next_capture_counter = CNT_ZERO;
    end else if (tick) begin
      if (compare_hit && capture_control_0[B_CLEAR_ON_CMP]) begin
        next_capture_counter = CNT_ZERO;
      end else if (counter_overflow_event) begin
        // reload on overflow; wrap to zero
        next_capture_counter = reload_enable ? counter_compare_reload : CNT_ZERO;
      end else begin
        next_capture_counter = capture_counter + 24'h000001;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      next_capture_hold_value[i] = capture_hold_value[i];
      if (capture_evt[i]) begin
        next_capture_hold_value[i] = capture_counter;
      end else if (wr_access && i_paddr == OFS_HOLD_0 + 8'(4 * i)) begin
        next_capture_hold_value[i] = i_pwdata[CNT_W-1:0];
      end
    end
  end

  // ****************************************
  // Software registers and status.
  // ****************************************
  always_comb begin
    next_counter_compare_reload = counter_compare_reload;
    next_capture_control_0      = capture_control_0;
    next_div_sel                = div_sel;
    if (wr_access) begin
      case (i_paddr)
        OFS_COMPARE:   next_counter_compare_reload = i_pwdata[CNT_W-1:0];
        OFS_CONTROL_0: next_capture_control_0 = i_pwdata;
        OFS_CONTROL_1: next_div_sel = i_pwdata[DIV_SEL_LO +: 2];
        OFS_IRQ_EN: begin
          next_capture_control_0[B_CAP_IRQ_EN_LO +: NCH] = i_pwdata[NCH-1:0];
          next_capture_control_0[B_OVF_IRQ_EN]           = i_pwdata[ST_OVF];
          next_capture_control_0[B_CMP_IRQ_EN]           = i_pwdata[ST_CMP];
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    next_status = status;
    if (wr_access && i_paddr == OFS_CLEAR) begin
      next_status = status & ~i_pwdata[ST_W-1:0];
    end
    next_status = next_status | {compare_hit, counter_overflow_event, capture_evt};
    next_irq    = |(next_status & next_irq_en(next_capture_control_0));
  end

  // ****************************************
  // APB read path, answered in the first access cycle.
  // ****************************************
  always_comb begin
    next_pready  = i_psel && !i_penable;
    next_prdata  = RST_WORD;
    map_hit      = 1'b1;
    case (i_paddr)
      OFS_COUNTER:   next_prdata[CNT_W-1:0] = capture_counter;
      OFS_HOLD_0:    next_prdata[CNT_W-1:0] = capture_hold_value[0];
      OFS_HOLD_1:    next_prdata[CNT_W-1:0] = capture_hold_value[1];
      OFS_HOLD_2:    next_prdata[CNT_W-1:0] = capture_hold_value[2];
      OFS_COMPARE:   next_prdata[CNT_W-1:0] = counter_compare_reload;
      OFS_CONTROL_0: next_prdata = capture_control_0;
      OFS_CONTROL_1: next_prdata[DIV_SEL_LO +: 2] = div_sel;
      OFS_STATUS:    next_prdata[ST_W-1:0] = status;
      OFS_CLEAR:     next_prdata = RST_WORD;
      OFS_IRQ_EN:    next_prdata[ST_W-1:0] = irq_en;
      default:       map_hit = 1'b0;
    endcase
    if (!(i_psel && !i_penable) || i_pwrite) begin
      next_prdata = RST_WORD;
    end
    next_pslverr = i_psel && !i_penable && (!map_hit || (i_pwrite && i_paddr == OFS_STATUS)
                   || (!i_pwrite && i_paddr == OFS_CLEAR));
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      capture_counter        <= CNT_ZERO;
      capture_hold_value     <= '{default: CNT_ZERO};
      counter_compare_reload <= CNT_ZERO;
      capture_control_0      <= RST_WORD;
      div_sel                <= 2'h0;
      status                 <= '0;
      input_prev             <= '0;
      o_prdata               <= RST_WORD;
      o_pready               <= 1'b0;
      o_pslverr              <= 1'b0;
      o_irq                  <= 1'b0;
    end else begin
      capture_counter        <= next_capture_counter;
      capture_hold_value     <= next_capture_hold_value;
      counter_compare_reload <= next_counter_compare_reload;
      capture_control_0      <= next_capture_control_0;
      div_sel                <= next_div_sel;
      status                 <= next_status;
      input_prev             <= i_capture_input;
      o_prdata               <= next_prdata;
      o_pready               <= next_pready;
      o_pslverr              <= next_pslverr;
      o_irq                  <= next_irq;
    end
  end

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_hold_latch_ch0: assert property (capture_evt[0] |=> capture_hold_value[0] == $past(capture_counter))
    else $error("Hold 0 did not take the counter value.");
  a_hold_own_input: assert property (!capture_evt[1] && !(wr_access && i_paddr == OFS_HOLD_1)
                                     |=> $stable(capture_hold_value[1]))
    else $error("Hold 1 changed without its own event.");
  a_match_sets_flag: assert property (tick && compare_enable && capture_counter == counter_compare_reload
                                      |=> status[ST_CMP])
    else $error("Compare match flag not set.");
  a_reload_on_ovf: assert property (counter_overflow_event && reload_enable && !capture_any
                                    && !(wr_access && i_paddr == OFS_COUNTER) && !compare_hit
                                    |=> capture_counter == $past(counter_compare_reload))
    else $error("Counter not reloaded on overflow.");
  a_tick_spacing: assert property (tick && div_sel == 2'h1 && $stable(div_sel) |=> !tick [*3])
    else $error("Divided tick came too early.");
  a_irq_level: assert property (##1 o_irq == |(status & irq_en))
    else $error("Interrupt level does not match enabled status.");
  a_wrap_to_zero: assert property (counter_overflow_event && !reload_enable && !capture_any
                                   && !(wr_access && i_paddr == OFS_COUNTER) && !compare_hit
                                   |=> capture_counter == CNT_ZERO)
    else $error("Counter did not wrap to zero.");
  a_clear_capture: assert property (capture_any && clear_on_capture && !reload_enable
                                    && !(wr_access && i_paddr == OFS_COUNTER)
                                    |=> capture_counter == CNT_ZERO)
    else $error("Counter not cleared after capture.");
  a_reserved_zero: assert property (i_psel && !i_penable && !i_pwrite && i_paddr >= OFS_HOLD_0
                                    && i_paddr <= OFS_COMPARE |=> o_prdata[31:24] == 8'h00)
    else $error("Reserved bits read nonzero.");

endmodule : capture_unit
`default_nettype wire
